// >>> hdl/cpc_regs.vh
// Register offsets, field positions, reset values and timing counts of the power configuration block.
`ifndef CPC_REGS_VH
`define CPC_REGS_VH

`define CPC_ADDR_CONFIG      5'h1C
`define CPC_ADDR_RSVD_29     5'h1D
`define CPC_ADDR_RSVD_30     5'h1E
`define CPC_ADDR_RSVD_31     5'h1F
`define CPC_ADDR_STATUS      5'h00

`define CPC_CONFIG_RESET     16'hC400
`define CPC_RSVD_RESET       16'h0000

`define CPC_BIT_PDN_REQ      15
`define CPC_BIT_AUTOCAL      14
`define CPC_BIT_CGEN3        13
`define CPC_BIT_CGEN2        12
`define CPC_BIT_CGEN1        11
`define CPC_BIT_CLKO_EN      10
`define CPC_BIT_XCTL_HI      9
`define CPC_BIT_XCTL_LO      8
`define CPC_BIT_CONVERSION_CLOCK_THREE_PIN_EN     7
`define CPC_BIT_BCLK3_EN     6
`define CPC_BIT_CONVERSION_CLOCK_TWO_PIN_EN     5
`define CPC_BIT_BCLK2_EN     4
`define CPC_BIT_CONVERSION_CLOCK_ONE_PIN_EN     3
`define CPC_BIT_BCLK1_EN     2
`define CPC_BIT_LINR_DIFF    1
`define CPC_BIT_LINL_DIFF    0
`define CPC_BIT_STATUS_PDN   14

`define CPC_CLK_HZ           25000000
`define CPC_PDN_TIME_US      5000
`define CPC_PUP_TIME_US      470000
`define CPC_CAL_TIME_US      4000
`define CPC_PDN_CYCLES       ((`CPC_PDN_TIME_US) * (`CPC_CLK_HZ / 1000000))
`define CPC_PUP_CYCLES       ((`CPC_PUP_TIME_US) * (`CPC_CLK_HZ / 1000000))
`define CPC_CAL_CYCLES       ((`CPC_CAL_TIME_US) * (`CPC_CLK_HZ / 1000000))

`endif

// >>> hdl/cpc_sync.v
// Two-stage synchroniser for a single level from outside the clock domain.
`default_nettype none
module cpc_sync
#(
	parameter RESET_VAL = 1'b0
)
(
	input  wire clk_in,
	input  wire rst_n_in,
	input  wire d_in,
	output wire q_out
);
	reg stage1_ff;
	reg stage2_ff;

	always @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			stage1_ff <= RESET_VAL;
			stage2_ff <= RESET_VAL;
		end
		else
		begin
			stage1_ff <= d_in;
			stage2_ff <= stage1_ff;
		end
	end

	assign q_out = stage2_ff;
endmodule
`default_nettype wire

// >>> hdl/cpc_power_config.v
// Fundamental configuration register and converter power-down sequencer.
`include "cpc_regs.vh"
`default_nettype none
module cpc_power_config
#(
	parameter integer PDN_CYCLES = `CPC_PDN_CYCLES,
	parameter integer PUP_CYCLES = `CPC_PUP_CYCLES,
	parameter integer CAL_CYCLES = `CPC_CAL_CYCLES
)
(
	input  wire        MCLK_IN,
	input  wire        RESET_N_IN,
	input  wire        HARD_POWERDOWN_PIN_N_IN,
	input  wire        WR_EN_IN,
	input  wire        RD_EN_IN,
	input  wire [4:0]  ADDR_IN,
	input  wire [15:0] WDATA_IN,
	input  wire        CLOCK_OUT_SRC_IN,
	input  wire [2:0]  CONV_CLOCK_SRC_IN,
	input  wire [2:0]  BIT_CLOCK_SRC_IN,
	output reg  [15:0] RDATA_OUT,
	output reg         RDATA_VALID_OUT,
	output reg         POWERDOWN_STATE_FLAG_OUT,
	output reg         SEQ_BUSY_OUT,
	output reg         CHANNELS_POWERDOWN_OUT,
	output reg         AUTOCAL_ACTIVE_OUT,
	output reg         SERIAL_IF_POWERDOWN_OUT,
	output reg         OSC_POWERDOWN_OUT,
	output reg  [2:0]  CLOCK_GEN_ENABLE_OUT,
	output reg         CLOCK_OUT_PIN_OUT,
	output reg         CLOCK_OUT_PIN_OE_OUT,
	output reg  [2:0]  CONVERSION_CLOCK_PIN_OUT,
	output reg  [2:0]  CONVERSION_CLOCK_PIN_OE_OUT,
	output reg  [2:0]  SERIAL_BIT_CLOCK_PIN_OUT,
	output reg  [2:0]  SERIAL_BIT_CLOCK_PIN_OE_OUT,
	output reg         EXT_CTRL_OUT_HIGH_OUT,
	output reg         EXT_CTRL_OUT_LOW_OUT,
	output reg         LINE_IN_RIGHT_DIFF_SELECT_OUT,
	output reg         LINE_IN_LEFT_DIFF_SELECT_OUT
);
	localparam [3:0] ST_UP   = 4'b0001;
	localparam [3:0] ST_DOWN = 4'b0010;
	localparam [3:0] ST_GOUP = 4'b0100;
	localparam [3:0] ST_DOWN_DONE = 4'b1000;
	localparam [15:0] CFG_DEFAULT = `CPC_CONFIG_RESET;

	////////////////////////////////////////////////////////////////////////////////
	// Hard power-down pin is asynchronous to the crystal clock.
	wire hard_pd_n_sync;

	cpc_sync #(.RESET_VAL(1'b0)) u_pd_sync
	(
		.clk_in   (MCLK_IN),
		.rst_n_in (RESET_N_IN),
		.d_in     (HARD_POWERDOWN_PIN_N_IN),
		.q_out    (hard_pd_n_sync)
	);

	wire hard_pd = ~hard_pd_n_sync;

	function [23:0] seq_len;
		input integer cycles;
		begin
			seq_len = cycles[23:0];
		end
	endfunction

	// The status bit counts the whole power-up wait as still powered down.
	function is_pd_state;
		input [3:0] st;
		begin
			is_pd_state = (st == ST_DOWN_DONE) || (st == ST_GOUP);
		end
	endfunction

	// Gathers three enable fields, highest channel first, into one pin-enable word.
	function [2:0] pick3;
		input [15:0]  cfg;
		input integer hi;
		input integer mid;
		input integer lo;
		begin
			pick3 = {cfg[hi], cfg[mid], cfg[lo]};
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	reg  [15:0] config_ff;
	reg  [15:0] rsvd29_ff;
	reg  [15:0] rsvd30_ff;
	reg  [15:0] rsvd31_ff;
	reg  [3:0]  state_ff;
	reg  [23:0] count_ff;
	reg         pending_ff;
	reg         exited_once_ff;
	reg         force_cal_ff;
	reg         cal_run_ff;

	reg  [15:0] nxt_config;
	reg  [3:0]  nxt_state;
	reg  [23:0] nxt_count;
	reg         nxt_pending;
	reg         nxt_exited_once;
	reg         nxt_force_cal;
	reg         nxt_cal_run;

	wire wr_cfg = WR_EN_IN && (ADDR_IN == `CPC_ADDR_CONFIG);
	wire req_now = config_ff[`CPC_BIT_PDN_REQ];
	wire req_wr  = WDATA_IN[`CPC_BIT_PDN_REQ];

	always @*
	begin
		nxt_config      = config_ff;
		nxt_state       = state_ff;
		nxt_count       = count_ff;
		nxt_pending     = pending_ff;
		nxt_exited_once = exited_once_ff;
		nxt_force_cal   = force_cal_ff;
		nxt_cal_run     = cal_run_ff;
		if (wr_cfg)
		begin
			// Request bit only changes when no transition is in flight.
			nxt_config[13:0] = WDATA_IN[13:0];
			if (!pending_ff)
				nxt_config[`CPC_BIT_PDN_REQ] = req_wr;
			// Autocal bit locked until the device has come out of power-down once.
			if (exited_once_ff)
				nxt_config[`CPC_BIT_AUTOCAL] = WDATA_IN[`CPC_BIT_AUTOCAL];
		end
		if (nxt_count != 24'h00_0000)
			nxt_count = count_ff - 24'h00_0001;
		case (state_ff)
			ST_UP:
			begin
				if (wr_cfg && !pending_ff && req_wr && !req_now)
				begin
					nxt_state   = ST_DOWN;
					nxt_count   = seq_len(PDN_CYCLES);
					nxt_pending = 1'b1;
				end
			end
			ST_DOWN:
			begin
				if (count_ff == 24'h00_0000)
				begin
					nxt_state   = ST_DOWN_DONE;
					nxt_pending = 1'b0;
				end
			end
			ST_DOWN_DONE:
			begin
				if (wr_cfg && !req_wr && req_now)
				begin
					nxt_state   = ST_GOUP;
					nxt_pending = 1'b1;
					// Autocal on exit when enabled, or once after reset or hard pin.
					nxt_cal_run = config_ff[`CPC_BIT_AUTOCAL] || force_cal_ff;
					nxt_count   = nxt_cal_run ? seq_len(PUP_CYCLES + CAL_CYCLES)
						: seq_len(PUP_CYCLES);
				end
			end
			ST_GOUP:
			begin
				if (count_ff == 24'h00_0000)
				begin
					nxt_state       = ST_UP;
					nxt_pending     = 1'b0;
					nxt_exited_once = 1'b1;
					nxt_force_cal   = 1'b0;
					nxt_cal_run     = 1'b0;
				end
			end
			default:
			begin
				nxt_state = ST_UP;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// The config default has the request bit set, so the block leaves reset powered down.
	always @(posedge MCLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			config_ff      <= `CPC_CONFIG_RESET;
			rsvd29_ff      <= `CPC_RSVD_RESET;
			rsvd30_ff      <= `CPC_RSVD_RESET;
			rsvd31_ff      <= `CPC_RSVD_RESET;
			state_ff       <= ST_DOWN_DONE;
			count_ff       <= 24'h00_0000;
			pending_ff     <= 1'b0;
			exited_once_ff <= 1'b0;
			force_cal_ff   <= 1'b1;
			cal_run_ff     <= 1'b0;
		end
		else if (hard_pd)
		begin
			config_ff      <= `CPC_CONFIG_RESET;
			rsvd29_ff      <= `CPC_RSVD_RESET;
			rsvd30_ff      <= `CPC_RSVD_RESET;
			rsvd31_ff      <= `CPC_RSVD_RESET;
			state_ff       <= ST_DOWN_DONE;
			count_ff       <= 24'h00_0000;
			pending_ff     <= 1'b0;
			exited_once_ff <= 1'b0;
			force_cal_ff   <= 1'b1;
			cal_run_ff     <= 1'b0;
		end
		else
		begin
			config_ff      <= nxt_config;
			// Reserved words keep their default; software must write zero there.
			rsvd29_ff      <= `CPC_RSVD_RESET;
			rsvd30_ff      <= `CPC_RSVD_RESET;
			rsvd31_ff      <= `CPC_RSVD_RESET;
			state_ff       <= nxt_state;
			count_ff       <= nxt_count;
			pending_ff     <= nxt_pending;
			exited_once_ff <= nxt_exited_once;
			force_cal_ff   <= nxt_force_cal;
			cal_run_ff     <= nxt_cal_run;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	reg [15:0] rd_mux;

	always @*
	begin
		case (ADDR_IN)
			`CPC_ADDR_STATUS:
			begin
				rd_mux = 16'h0000;
				rd_mux[`CPC_BIT_STATUS_PDN] = is_pd_state(state_ff);
			end
			`CPC_ADDR_CONFIG:  rd_mux = config_ff;
			`CPC_ADDR_RSVD_29: rd_mux = rsvd29_ff;
			`CPC_ADDR_RSVD_30: rd_mux = rsvd30_ff;
			`CPC_ADDR_RSVD_31: rd_mux = rsvd31_ff;
			default:           rd_mux = 16'h0000;
		endcase
	end

	wire pd_flag = is_pd_state(nxt_state);

	// While the hard pin holds the block, the field outputs show the held default at once
	// instead of lagging one cycle behind the register clear.
	wire [15:0] eff_cfg = hard_pd ? CFG_DEFAULT : nxt_config;

	////////////////////////////////////////////////////////////////////////////////
	// Read port and sequencer status.
	always @(posedge MCLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			RDATA_OUT                     <= 16'h0000;
			RDATA_VALID_OUT               <= 1'b0;
			POWERDOWN_STATE_FLAG_OUT      <= 1'b1;
			SEQ_BUSY_OUT                  <= 1'b0;
			CHANNELS_POWERDOWN_OUT        <= 1'b1;
			AUTOCAL_ACTIVE_OUT            <= 1'b0;
			SERIAL_IF_POWERDOWN_OUT       <= 1'b1;
			OSC_POWERDOWN_OUT             <= 1'b1;
		end
		else
		begin
			RDATA_OUT                     <= RD_EN_IN ? rd_mux : 16'h0000;
			RDATA_VALID_OUT               <= RD_EN_IN;
			POWERDOWN_STATE_FLAG_OUT      <= hard_pd | pd_flag;
			SEQ_BUSY_OUT                  <= ~hard_pd & nxt_pending;
			CHANNELS_POWERDOWN_OUT        <= hard_pd | (nxt_state != ST_UP);
			AUTOCAL_ACTIVE_OUT            <= ~hard_pd & nxt_cal_run;
			SERIAL_IF_POWERDOWN_OUT       <= hard_pd;
			OSC_POWERDOWN_OUT             <= hard_pd;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Configuration fields that leave the block as levels.
	always @(posedge MCLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			CLOCK_GEN_ENABLE_OUT          <= 3'h0;
			EXT_CTRL_OUT_HIGH_OUT         <= 1'b0;
			EXT_CTRL_OUT_LOW_OUT          <= 1'b0;
			LINE_IN_RIGHT_DIFF_SELECT_OUT <= 1'b0;
			LINE_IN_LEFT_DIFF_SELECT_OUT  <= 1'b0;
		end
		else
		begin
			CLOCK_GEN_ENABLE_OUT          <= eff_cfg[`CPC_BIT_CGEN3:`CPC_BIT_CGEN1];
			EXT_CTRL_OUT_HIGH_OUT         <= eff_cfg[`CPC_BIT_XCTL_HI];
			EXT_CTRL_OUT_LOW_OUT          <= eff_cfg[`CPC_BIT_XCTL_LO];
			LINE_IN_RIGHT_DIFF_SELECT_OUT <= eff_cfg[`CPC_BIT_LINR_DIFF];
			LINE_IN_LEFT_DIFF_SELECT_OUT  <= eff_cfg[`CPC_BIT_LINL_DIFF];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin drivers: clock sources are retimed by one flop, enables follow their fields.
	always @(posedge MCLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			CLOCK_OUT_PIN_OUT             <= 1'b0;
			// The default word has the clock-out field set, so that pin drives from reset.
			CLOCK_OUT_PIN_OE_OUT          <= CFG_DEFAULT[`CPC_BIT_CLKO_EN];
			CONVERSION_CLOCK_PIN_OUT      <= 3'h0;
			CONVERSION_CLOCK_PIN_OE_OUT   <= 3'h0;
			SERIAL_BIT_CLOCK_PIN_OUT      <= 3'h0;
			SERIAL_BIT_CLOCK_PIN_OE_OUT   <= 3'h0;
		end
		else
		begin
			CLOCK_OUT_PIN_OUT             <= CLOCK_OUT_SRC_IN;
			CLOCK_OUT_PIN_OE_OUT          <= eff_cfg[`CPC_BIT_CLKO_EN];
			CONVERSION_CLOCK_PIN_OUT      <= CONV_CLOCK_SRC_IN;
			CONVERSION_CLOCK_PIN_OE_OUT   <= pick3(eff_cfg, `CPC_BIT_CONVERSION_CLOCK_THREE_PIN_EN,
				`CPC_BIT_CONVERSION_CLOCK_TWO_PIN_EN, `CPC_BIT_CONVERSION_CLOCK_ONE_PIN_EN);
			SERIAL_BIT_CLOCK_PIN_OUT      <= BIT_CLOCK_SRC_IN;
			SERIAL_BIT_CLOCK_PIN_OE_OUT   <= pick3(eff_cfg, `CPC_BIT_BCLK3_EN,
				`CPC_BIT_BCLK2_EN, `CPC_BIT_BCLK1_EN);
		end
	end
endmodule
`default_nettype wire

// >>> dv/cpc_props.sv
// Port-level concurrent checks for the power configuration block.
`default_nettype none
module cpc_props
#(
	parameter int PDN_CYCLES = 20,
	parameter int PUP_CYCLES = 50,
	parameter int CAL_CYCLES = 10
)
(
	input wire logic        MCLK_IN,
	input wire logic        RESET_N_IN,
	input wire logic        HARD_POWERDOWN_PIN_N_IN,
	input wire logic        WR_EN_IN,
	input wire logic        RD_EN_IN,
	input wire logic [4:0]  ADDR_IN,
	input wire logic [15:0] WDATA_IN,
	input wire logic [15:0] RDATA_OUT,
	input wire logic        RDATA_VALID_OUT,
	input wire logic        POWERDOWN_STATE_FLAG_OUT,
	input wire logic        SEQ_BUSY_OUT,
	input wire logic        AUTOCAL_ACTIVE_OUT,
	input wire logic        SERIAL_IF_POWERDOWN_OUT,
	input wire logic        OSC_POWERDOWN_OUT,
	input wire logic [2:0]  CLOCK_GEN_ENABLE_OUT,
	input wire logic        CLOCK_OUT_PIN_OE_OUT,
	input wire logic [2:0]  CONVERSION_CLOCK_PIN_OE_OUT,
	input wire logic [2:0]  SERIAL_BIT_CLOCK_PIN_OE_OUT,
	input wire logic        EXT_CTRL_OUT_HIGH_OUT,
	input wire logic        EXT_CTRL_OUT_LOW_OUT,
	input wire logic        LINE_IN_RIGHT_DIFF_SELECT_OUT,
	input wire logic        LINE_IN_LEFT_DIFF_SELECT_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PD_LO = PDN_CYCLES - 3;
	localparam int PD_HI = PDN_CYCLES + 3;
	localparam int PU_LO = PUP_CYCLES - 3;
	localparam int PU_HI = PUP_CYCLES + 3;
	localparam int PC_LO = PUP_CYCLES + CAL_CYCLES - 3;
	localparam int PC_HI = PUP_CYCLES + CAL_CYCLES + 3;
	logic [1:0] pin_cnt_ff;
	logic       wr_cfg;
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!RESET_N_IN);
	// The pin passes a synchroniser, so writes count only once it has been high a while.
	assign wr_cfg = WR_EN_IN && (ADDR_IN == 5'h1C) && (pin_cnt_ff == 2'h3);
	always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
			pin_cnt_ff <= 2'h0;
		else if (!HARD_POWERDOWN_PIN_N_IN)
			pin_cnt_ff <= 2'h0;
		else if (pin_cnt_ff != 2'h3)
			pin_cnt_ff <= pin_cnt_ff + 2'h1;
	end
	property p_clko; wr_cfg |=> CLOCK_OUT_PIN_OE_OUT == $past(WDATA_IN[10]); endproperty
	a_clko: assert property (p_clko) else $error("clock out enable wrong");
	property p_conv; wr_cfg |=> CONVERSION_CLOCK_PIN_OE_OUT ==
		{$past(WDATA_IN[7]), $past(WDATA_IN[5]), $past(WDATA_IN[3])}; endproperty
	a_conv: assert property (p_conv) else $error("conversion clock enable wrong");
	property p_bclk; wr_cfg |=> SERIAL_BIT_CLOCK_PIN_OE_OUT ==
		{$past(WDATA_IN[6]), $past(WDATA_IN[4]), $past(WDATA_IN[2])}; endproperty
	a_bclk: assert property (p_bclk) else $error("bit clock enable wrong");
	property p_xctl; wr_cfg |=> {EXT_CTRL_OUT_HIGH_OUT, EXT_CTRL_OUT_LOW_OUT} == $past(WDATA_IN[9:8]);
	endproperty
	a_xctl: assert property (p_xctl) else $error("external control pins wrong");
	property p_lin; wr_cfg |=> {LINE_IN_RIGHT_DIFF_SELECT_OUT, LINE_IN_LEFT_DIFF_SELECT_OUT} ==
		$past(WDATA_IN[1:0]); endproperty
	a_lin: assert property (p_lin) else $error("line input select wrong");
	property p_cgen; wr_cfg |=> CLOCK_GEN_ENABLE_OUT == $past(WDATA_IN[13:11]); endproperty
	a_cgen: assert property (p_cgen) else $error("clock generator enables wrong");
	property p_rsvd; RD_EN_IN && ADDR_IN >= 5'h1D |=> RDATA_VALID_OUT && RDATA_OUT == 16'h0000;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved word not zero");
	property p_hard; !HARD_POWERDOWN_PIN_N_IN [*4] |-> SERIAL_IF_POWERDOWN_OUT && OSC_POWERDOWN_OUT;
	endproperty
	a_hard: assert property (p_hard) else $error("deep power down missing");
	property p_def; !HARD_POWERDOWN_PIN_N_IN [*4] |-> CLOCK_GEN_ENABLE_OUT == 3'h0 &&
		CLOCK_OUT_PIN_OE_OUT && POWERDOWN_STATE_FLAG_OUT; endproperty
	a_def: assert property (p_def) else $error("default not held under pin");
	property p_pdn; $rose(SEQ_BUSY_OUT) && !POWERDOWN_STATE_FLAG_OUT |->
		##[PD_LO:PD_HI] $rose(POWERDOWN_STATE_FLAG_OUT); endproperty
	a_pdn: assert property (p_pdn) else $error("power down time wrong");
	property p_pup; $rose(SEQ_BUSY_OUT) && POWERDOWN_STATE_FLAG_OUT && !AUTOCAL_ACTIVE_OUT |->
		##[PU_LO:PU_HI] $fell(POWERDOWN_STATE_FLAG_OUT); endproperty
	a_pup: assert property (p_pup) else $error("power up time wrong");
	property p_pcal; $rose(SEQ_BUSY_OUT) && POWERDOWN_STATE_FLAG_OUT && AUTOCAL_ACTIVE_OUT |->
		##[PC_LO:PC_HI] $fell(POWERDOWN_STATE_FLAG_OUT); endproperty
	a_pcal: assert property (p_pcal) else $error("calibrated power up time wrong");
	c_up: cover property ($fell(POWERDOWN_STATE_FLAG_OUT));
	c_down: cover property ($rose(POWERDOWN_STATE_FLAG_OUT));
	c_wr: cover property (wr_cfg);
endmodule
`default_nettype wire

// >>> dv/cpc_dsp_model.sv
// Control-word master standing in for the DSP on the register port.
`default_nettype none
module cpc_dsp_model
(
	input  wire logic        clk_in,
	input  wire logic [15:0] rdata_in,
	input  wire logic        rvalid_in,
	output logic             wr_en_out,
	output logic             rd_en_out,
	output logic [4:0]       addr_out,
	output logic [15:0]      wdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		wr_en_out = 1'b0;
		rd_en_out = 1'b0;
		addr_out = 5'h00;
		wdata_out = 16'h0000;
	end
	// Idle lines carry the inverse of the last word so a stale value never passes as fresh.
	task automatic write_word(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_in);
		wr_en_out <= 1'b1;
		addr_out <= a;
		wdata_out <= (a >= 5'h1D) ? 16'h0000 : d;
		@(posedge clk_in);
		wr_en_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~wdata_out;
	endtask
	task automatic read_word(input logic [4:0] a, output logic [15:0] d, output logic v);
		@(posedge clk_in);
		rd_en_out <= 1'b1;
		addr_out <= a;
		@(posedge clk_in);
		rd_en_out <= 1'b0;
		addr_out <= ~a;
		@(posedge clk_in);
		d = rdata_in;
		v = rvalid_in;
	endtask
endmodule
`default_nettype wire

// >>> dv/cpc_power_config_test.sv
// Self-checking bench for the power configuration block.
`default_nettype none
module cpc_power_config_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PDN = 20;
	localparam int PUP = 50;
	localparam int CAL = 10;
	logic             MCLK_IN, RESET_N_IN, pin_n;
	logic [6:0]       src;
	int               n_mismatch, n_tests, cyc, n, i;
	logic [15:0]      pat [3] = '{16'h3FFF, 16'h2A55, 16'h0000};
	wire logic        wr, rd, rvalid, flag, busy, chpd, acal, sipd, oscpd;
	wire logic        clko_oe, xhi, xlo, linr, linl, clko_pin;
	wire logic [4:0]  addr;
	wire logic [15:0] wdata, rdata;
	wire logic [2:0]  cgen, conv_oe, bclk_oe, conv_pin, bclk_pin;
	cpc_power_config #(.PDN_CYCLES(PDN), .PUP_CYCLES(PUP), .CAL_CYCLES(CAL)) dut_u (
		.MCLK_IN(MCLK_IN), .RESET_N_IN(RESET_N_IN), .HARD_POWERDOWN_PIN_N_IN(pin_n),
		.WR_EN_IN(wr), .RD_EN_IN(rd), .ADDR_IN(addr), .WDATA_IN(wdata),
		.CLOCK_OUT_SRC_IN(src[0]), .CONV_CLOCK_SRC_IN(src[3:1]), .BIT_CLOCK_SRC_IN(src[6:4]),
		.RDATA_OUT(rdata), .RDATA_VALID_OUT(rvalid), .POWERDOWN_STATE_FLAG_OUT(flag),
		.SEQ_BUSY_OUT(busy), .CHANNELS_POWERDOWN_OUT(chpd), .AUTOCAL_ACTIVE_OUT(acal),
		.SERIAL_IF_POWERDOWN_OUT(sipd), .OSC_POWERDOWN_OUT(oscpd), .CLOCK_GEN_ENABLE_OUT(cgen),
		.CLOCK_OUT_PIN_OUT(clko_pin), .CLOCK_OUT_PIN_OE_OUT(clko_oe),
		.CONVERSION_CLOCK_PIN_OUT(conv_pin),
		.CONVERSION_CLOCK_PIN_OE_OUT(conv_oe), .SERIAL_BIT_CLOCK_PIN_OUT(bclk_pin),
		.SERIAL_BIT_CLOCK_PIN_OE_OUT(bclk_oe), .EXT_CTRL_OUT_HIGH_OUT(xhi),
		.EXT_CTRL_OUT_LOW_OUT(xlo), .LINE_IN_RIGHT_DIFF_SELECT_OUT(linr),
		.LINE_IN_LEFT_DIFF_SELECT_OUT(linl));
	cpc_dsp_model dsp_u (.clk_in(MCLK_IN), .rdata_in(rdata), .rvalid_in(rvalid), .wr_en_out(wr),
		.rd_en_out(rd), .addr_out(addr), .wdata_out(wdata));
	initial
	begin
		MCLK_IN = 1'b0;
		forever #20 MCLK_IN = ~MCLK_IN;
	end
	always @(posedge MCLK_IN)
	begin
		src <= src + 7'h01;
		cyc = cyc + 1;
		if (cyc == 3000)
		begin
			n_mismatch = n_mismatch + 1;
			print_verdict();
		end
	end
	task automatic check(input logic [15:0] s, input logic [15:0] e);
		n_tests = n_tests + 1;
		if (s !== e)
		begin
			n_mismatch = n_mismatch + 1;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
		logic [15:0] d;
		logic        v;
		dsp_u.read_word(a, d, v);
		check(d, e);
		check(16'(v), 16'h0001);
	endtask
	// Elapsed counts carry a cycle or two of bench overhead, hence the tolerance.
	task automatic wait_idle(input int e);
		n = 0;
		@(negedge MCLK_IN);
		while (busy !== 1'b0 && n < 1000)
		begin
			@(negedge MCLK_IN);
			n = n + 1;
		end
		check(16'(n >= e - 4 && n <= e + 4), 16'h0001);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic t_reset();
		rd_chk(5'h1C, 16'hC400);
		for (i = 29; i < 32; i++)
			rd_chk(5'(i), 16'h0000);
		rd_chk(5'h00, 16'h4000);
		rd_chk(5'h05, 16'h0000);
		check(16'({chpd, clko_oe, cgen}), 16'h0018);
		$display("reset test done");
	endtask
	task automatic t_first_up();
		dsp_u.write_word(5'h1C, 16'h0000);
		dsp_u.write_word(5'h1C, 16'h8000);
		@(negedge MCLK_IN);
		check(16'({busy, acal}), 16'h0003);
		wait_idle(PUP + CAL - 2);
		check(16'({flag, chpd}), 16'h0000);
		rd_chk(5'h1C, 16'h4000);
		$display("first power up test done");
	endtask
	task automatic t_fields();
		for (i = 0; i < 3; i++)
		begin
			dsp_u.write_word(5'h1C, pat[i]);
			@(negedge MCLK_IN);
			check(16'({cgen, clko_oe, xhi, xlo, conv_oe, bclk_oe, linr, linl}), 16'({pat[i][13:8],
				pat[i][7], pat[i][5], pat[i][3], pat[i][6], pat[i][4], pat[i][2], pat[i][1:0]}));
			check(16'({bclk_pin, conv_pin, clko_pin}), 16'(7'(src - 7'h01)));
			rd_chk(5'h1C, pat[i]);
		end
		$display("field test done");
	endtask
	task automatic t_down_up();
		dsp_u.write_word(5'h1C, 16'h8000);
		@(negedge MCLK_IN);
		check(16'({busy, flag, chpd}), 16'h0005);
		wait_idle(PDN - 1);
		check(16'(flag), 16'h0001);
		dsp_u.write_word(5'h1C, 16'h0000);
		@(negedge MCLK_IN);
		check(16'(acal), 16'h0000);
		wait_idle(PUP - 1);
		$display("power down and up test done");
	endtask
	task automatic t_hard();
		dsp_u.write_word(5'h1C, 16'h3800);
		pin_n <= 1'b0;
		repeat (5) @(posedge MCLK_IN);
		dsp_u.write_word(5'h1C, 16'h0300);
		@(negedge MCLK_IN);
		check(16'({sipd, oscpd, flag, chpd, cgen, clko_oe, xhi, xlo}), 16'h03C4);
		@(posedge MCLK_IN);
		pin_n <= 1'b1;
		repeat (4) @(posedge MCLK_IN);
		rd_chk(5'h1C, 16'hC400);
		dsp_u.write_word(5'h1C, 16'h0000);
		@(negedge MCLK_IN);
		check(16'(acal), 16'h0001);
		wait_idle(PUP + CAL - 1);
		$display("hard power down test done");
	endtask
	initial
	begin
		RESET_N_IN = 1'b0;
		pin_n = 1'b1;
		src = 7'h00;
		n_mismatch = 0;
		n_tests = 0;
		cyc = 0;
		repeat (3) @(posedge MCLK_IN);
		RESET_N_IN <= 1'b1;
		t_reset();
		t_first_up();
		t_fields();
		t_down_up();
		t_hard();
		print_verdict();
	end
endmodule
bind cpc_power_config cpc_props #(.PDN_CYCLES(PDN_CYCLES), .PUP_CYCLES(PUP_CYCLES),
	.CAL_CYCLES(CAL_CYCLES)) props_u (.MCLK_IN(MCLK_IN), .RESET_N_IN(RESET_N_IN),
	.HARD_POWERDOWN_PIN_N_IN(HARD_POWERDOWN_PIN_N_IN), .WR_EN_IN(WR_EN_IN), .RD_EN_IN(RD_EN_IN),
	.ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .RDATA_OUT(RDATA_OUT),
	.RDATA_VALID_OUT(RDATA_VALID_OUT), .POWERDOWN_STATE_FLAG_OUT(POWERDOWN_STATE_FLAG_OUT),
	.SEQ_BUSY_OUT(SEQ_BUSY_OUT), .AUTOCAL_ACTIVE_OUT(AUTOCAL_ACTIVE_OUT),
	.SERIAL_IF_POWERDOWN_OUT(SERIAL_IF_POWERDOWN_OUT), .OSC_POWERDOWN_OUT(OSC_POWERDOWN_OUT),
	.CLOCK_GEN_ENABLE_OUT(CLOCK_GEN_ENABLE_OUT), .CLOCK_OUT_PIN_OE_OUT(CLOCK_OUT_PIN_OE_OUT),
	.CONVERSION_CLOCK_PIN_OE_OUT(CONVERSION_CLOCK_PIN_OE_OUT),
	.SERIAL_BIT_CLOCK_PIN_OE_OUT(SERIAL_BIT_CLOCK_PIN_OE_OUT),
	.EXT_CTRL_OUT_HIGH_OUT(EXT_CTRL_OUT_HIGH_OUT), .EXT_CTRL_OUT_LOW_OUT(EXT_CTRL_OUT_LOW_OUT),
	.LINE_IN_RIGHT_DIFF_SELECT_OUT(LINE_IN_RIGHT_DIFF_SELECT_OUT),
	.LINE_IN_LEFT_DIFF_SELECT_OUT(LINE_IN_LEFT_DIFF_SELECT_OUT));
`default_nettype wire
